// ### nwc_pkg.sv
// nwc_pkg: register map, field positions and types of the nvm write control
package nwc_pkg;

	// ----------------------------------------
	// register map (word index on the plain port)
	// ----------------------------------------
	localparam int NWC_ADDR_W = 3;
	localparam logic [2:0] ADR_CONTROL = 3'h0;
	localparam logic [2:0] ADR_UNLOCK_KEY = 3'h1;
	localparam logic [2:0] ADR_BYTE_DATA = 3'h2;
	localparam logic [2:0] ADR_BYTE_ADDRESS = 3'h3;
	localparam logic [2:0] ADR_IRQ_FLAGS_TWO = 3'h4;

	// ----------------------------------------
	// control register fields and the done flag bit of the irq flags register
	// ----------------------------------------
	localparam int B_MEMORY_SELECT = 7;
	localparam int B_CONFIG_SELECT = 6;
	localparam int B_UNUSED = 5;
	localparam int B_ROW_ERASE = 4;
	localparam int B_WRITE_ERROR = 3;
	localparam int B_WRITE_ENABLE = 2;
	localparam int B_WRITE_START = 1;
	localparam int B_READ_START = 0;
	localparam int B_WRITE_DONE_IRQ = 4;

	// ----------------------------------------
	// unlock keys and reset values
	// ----------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_FREQ_MHZ = 125;
	localparam int WRITE_TIME_US = 4000;
	localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_FREQ_MHZ;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {TGT_EEPROM, TGT_FLASH, TGT_CONFIG} nwc_target_t;

	typedef struct packed {
		logic start;
		logic busy;
		logic erase;
		nwc_target_t target;
		logic [7:0] addr;
		logic [7:0] data;
	} nwc_mem_cmd_t;

endpackage

// ### nwc_write_control.sv
// nwc_write_control: control, unlock and self-timed write logic for nvm
//
// Operation
// - memory select 0 targets data EEPROM, 1 targets program flash.
// - config select 1 targets configuration space, overriding memory select.
// - write enable gates every erase/write; cleared at power-up.
// - error flag set when write enable set, cleared on timed completion.
// - error flag 1 means write aborted by reset or improper attempt.
// - memory and config select bits survive a write error unchanged.
// - write start is set-only by software, cleared by hardware on finish.
// - write start launches EEPROM write, flash erase or flash write.
// - completion sets the done interrupt flag; only software clears it.
// - read start completes in one cycle and self-clears; set-only.
// - read start ignored while memory select or config select is 1.
// - row erase makes next start erase a flash row; cleared when done.
// - unlock key register stores nothing and reads as zero.
// - data EEPROM access is one byte at a byte address.
// - an EEPROM byte write erases the byte before programming it.
// - write duration is timed by the block's own timer.
// - bit 5 of the control register always reads zero.
// - write start blocked unless write enable was already set.
// - control, address and data registers locked while a write runs.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
module nwc_write_control
	import nwc_pkg::*;
#(
	parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic warmReset,
	input wire logic [NWC_ADDR_W-1:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [7:0] busRdata,
	input wire logic [7:0] memRdata,
	output nwc_mem_cmd_t memCmd
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {UNL_IDLE, UNL_GOT_FIRST, UNL_ARMED} nwc_unlock_t;

	localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(WRITE_CYCLES - 1);
	localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;

	nwc_unlock_t unlockState;
	logic memorySelect;
	logic configSelect;
	logic rowErase;
	logic writeErrorFlag;
	logic writeEnableBit;
	logic writeStart;
	logic readStart;
	logic writeDoneIrqFlag;
	logic [7:0] byteData;
	logic [7:0] byteAddress;
	logic [TIMER_W-1:0] timer;

	logic ctlWrite;
	logic launch;
	logic finish;
	logic improper;

	function automatic logic isWrite(input logic [NWC_ADDR_W-1:0] a,
		input logic [NWC_ADDR_W-1:0] target);
		isWrite = busWrite && (a == target);
	endfunction

	assign ctlWrite = isWrite(busAddr, ADR_CONTROL);
	// a locked block ignores the start; arming also needs the prior enable
	assign launch = ctlWrite && busWdata[B_WRITE_START] && !writeStart
		&& writeEnableBit && unlockState == UNL_ARMED
		&& !warmReset;
	assign finish = writeStart && timer == TIMER_ZERO;
	assign improper = ctlWrite && busWdata[B_WRITE_START] && !writeStart
		&& !launch;

	// ----------------------------------------
	// unlock sequence
	// ----------------------------------------
	// any bus access other than the expected next step drops the progress
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			unlockState <= UNL_IDLE;
		else if (warmReset)
			unlockState <= UNL_IDLE;
		else if (busWrite || busRead)
		begin
			if (isWrite(busAddr, ADR_UNLOCK_KEY) && busWdata == KEY_FIRST)
				unlockState <= UNL_GOT_FIRST;
			else if (unlockState == UNL_GOT_FIRST
				&& isWrite(busAddr, ADR_UNLOCK_KEY) && busWdata == KEY_SECOND)
				unlockState <= UNL_ARMED;
			else
				unlockState <= UNL_IDLE;
		end
	end

	// ----------------------------------------
	// target selection
	// ----------------------------------------
	// selects are not touched by a warm reset so an aborted target stays visible
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			memorySelect <= 1'b0;
			configSelect <= 1'b0;
		end
		else if (ctlWrite && !writeStart && !warmReset)
		begin
			memorySelect <= busWdata[B_MEMORY_SELECT];
			configSelect <= busWdata[B_CONFIG_SELECT];
		end
	end

	// ----------------------------------------
	// enable and row erase
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			writeEnableBit <= 1'b0;
			rowErase <= 1'b0;
		end
		else if (warmReset)
		begin
			writeEnableBit <= 1'b0;
			rowErase <= 1'b0;
		end
		else if (finish)
			rowErase <= 1'b0;
		else if (ctlWrite && !writeStart)
		begin
			writeEnableBit <= busWdata[B_WRITE_ENABLE];
			rowErase <= busWdata[B_ROW_ERASE];
		end
	end

	// ----------------------------------------
	// write start and timer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			writeStart <= 1'b0;
		else if (warmReset || finish)
			writeStart <= 1'b0;
		else if (launch)
			writeStart <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timer <= TIMER_ZERO;
		else if (launch)
			timer <= TIMER_LOAD;
		else if (writeStart && timer != TIMER_ZERO)
			timer <= timer - 1'b1;
	end

	// ----------------------------------------
	// read start
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			readStart <= 1'b0;
		else if (readStart || warmReset)
			readStart <= 1'b0;
		else if (ctlWrite && !writeStart)
			readStart <= busWdata[B_READ_START]
				&& !busWdata[B_MEMORY_SELECT]
				&& !busWdata[B_CONFIG_SELECT];
	end

	// ----------------------------------------
	// write error flag
	// ----------------------------------------
	// set on enable, launch or an improper start; a clean finish or a control write of 0 clears it,
	// so a write cut short by a warm reset still reads 1
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			writeErrorFlag <= 1'b0;
		else if (finish)
			writeErrorFlag <= 1'b0;
		else if (improper)
			writeErrorFlag <= 1'b1;
		else if (launch)
			writeErrorFlag <= 1'b1;
		else if (ctlWrite && !writeStart && !warmReset)
			writeErrorFlag <= busWdata[B_WRITE_ENABLE] && !writeEnableBit
				? 1'b1 : busWdata[B_WRITE_ERROR];
	end

	// ----------------------------------------
	// done interrupt flag
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			writeDoneIrqFlag <= 1'b0;
		else if (finish)
			writeDoneIrqFlag <= 1'b1;
		else if (isWrite(busAddr, ADR_IRQ_FLAGS_TWO))
			writeDoneIrqFlag <= busWdata[B_WRITE_DONE_IRQ];
	end

	// ----------------------------------------
	// byte data and address
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			byteData <= BYTE_RESET;
		else if (readStart)
			byteData <= memRdata;
		else if (isWrite(busAddr, ADR_BYTE_DATA) && !writeStart)
			byteData <= busWdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			byteAddress <= BYTE_RESET;
		else if (isWrite(busAddr, ADR_BYTE_ADDRESS) && !writeStart)
			byteAddress <= busWdata;
	end

	// ----------------------------------------
	// memory command
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			memCmd <= '0;
		else
		begin
			memCmd.start <= launch;
			memCmd.busy <= (launch || (writeStart && !finish)) && !warmReset;
			if (configSelect)
				memCmd.target <= TGT_CONFIG;
			else if (memorySelect)
				memCmd.target <= TGT_FLASH;
			else
				memCmd.target <= TGT_EEPROM;
			// an eeprom byte write always erases first
			memCmd.erase <= memorySelect || configSelect
				? rowErase : 1'b1;
			memCmd.addr <= byteAddress;
			memCmd.data <= byteData;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	function automatic logic [7:0] readMux(input logic [NWC_ADDR_W-1:0] a);
		logic [7:0] r;
		r = '0;
		case (a)
			ADR_CONTROL:
			begin
				r[B_MEMORY_SELECT] = memorySelect;
				r[B_CONFIG_SELECT] = configSelect;
				r[B_UNUSED] = 1'b0;
				r[B_ROW_ERASE] = rowErase;
				r[B_WRITE_ERROR] = writeErrorFlag;
				r[B_WRITE_ENABLE] = writeEnableBit;
				r[B_WRITE_START] = writeStart;
				r[B_READ_START] = readStart;
			end
			ADR_UNLOCK_KEY: r = '0;
			ADR_BYTE_DATA: r = byteData;
			ADR_BYTE_ADDRESS: r = byteAddress;
			ADR_IRQ_FLAGS_TWO: r[B_WRITE_DONE_IRQ] = writeDoneIrqFlag;
			default: r = '0;
		endcase
		readMux = r;
	endfunction

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			busRdata <= '0;
		else
			busRdata <= busRead ? readMux(busAddr) : '0;
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_read_self_clear: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(readStart) |=> !readStart)
		else $error("read start did not clear after one cycle");

	a_read_blocked: assert property (
		@(posedge clk) disable iff (!rst_n)
		readStart |-> !memorySelect && !configSelect)
		else $error("read start set with program or config target");

	a_start_needs_en: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(writeStart) |-> $past(writeEnableBit))
		else $error("write started without prior enable");

	a_start_unlocked: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(writeStart) |-> $past(unlockState) == UNL_ARMED)
		else $error("write started without unlock sequence");

	a_finish_flags: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(writeStart) && !$past(warmReset)
		|-> writeDoneIrqFlag && !writeErrorFlag)
		else $error("finish did not set done flag and clear error");

	a_regs_locked: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeStart && $past(writeStart)
		|-> $stable(byteAddress) && $stable(byteData))
		else $error("address or data changed during a write");

	a_select_hold: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(writeStart) && !writeStart
		|-> $stable(memorySelect) && $stable(configSelect))
		else $error("target select changed at write end");

	a_key_reads_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(busRead) && $past(busAddr) == ADR_UNLOCK_KEY
		|-> busRdata == BYTE_RESET)
		else $error("unlock key read nonzero");

	a_bit5_zero: assert property (
		@(posedge clk) disable iff (!rst_n)
		busRdata[B_UNUSED] == 1'b0 || $past(busAddr) != ADR_CONTROL)
		else $error("unused control bit read as one");

	a_start_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(writeStart) |-> memCmd.start && memCmd.busy)
		else $error("memory command not launched with write start");

	a_abort_error: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(writeStart) && $past(warmReset) && !$past(finish)
		|-> writeErrorFlag)
		else $error("aborted write did not leave the error flag set");

	a_row_cleared: assert property (
		@(posedge clk) disable iff (!rst_n)
		$fell(writeStart) |-> !rowErase)
		else $error("row erase still set after the write ended");

	a_sel_locked: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeStart && $past(writeStart) |-> $stable(memorySelect)
		&& $stable(configSelect) && $stable(rowErase))
		else $error("control bits changed during a write");

	a_run_enabled: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeStart |-> writeEnableBit)
		else $error("write running without write enable");

	a_done_held: assert property (
		@(posedge clk) disable iff (!rst_n)
		writeDoneIrqFlag && !(busWrite && busAddr == ADR_IRQ_FLAGS_TWO)
		|=> writeDoneIrqFlag)
		else $error("done flag cleared without a software write");

	c_eeprom_write: cover property (@(posedge clk) disable iff (!rst_n)
		memCmd.start && memCmd.target == TGT_EEPROM);
	c_flash_erase: cover property (@(posedge clk) disable iff (!rst_n)
		memCmd.start && memCmd.target == TGT_FLASH && memCmd.erase);
	c_aborted: cover property (@(posedge clk) disable iff (!rst_n)
		writeStart && warmReset);
	c_read: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(readStart));

endmodule

// ### nwc_nvm_model.sv
// nwc_nvm_model: behavioural data EEPROM array behind the write control
module nwc_nvm_model
	import nwc_pkg::*;
(
	input wire logic clk,
	input wire nwc_mem_cmd_t memCmd,
	output logic [7:0] memRdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// byte array
	// ----------------------------------------
	logic [7:0] cells [256];
	logic pend = 1'b0;
	logic [7:0] pAddr;
	logic [7:0] pData;

	// a byte still being programmed reads as erased, never as the new value
	assign memRdata = (pend && memCmd.addr == pAddr) ? 8'hFF
		: cells[memCmd.addr];

	initial
	begin
		foreach (cells[i]) cells[i] = 8'h00;
	end

	always @(posedge clk)
	begin
		if (memCmd.start && memCmd.target == TGT_EEPROM)
		begin
			// erase first, program when busy drops at the timer's end or on a warm reset
			pend <= 1'b1;
			pAddr <= memCmd.addr;
			pData <= memCmd.data;
			cells[memCmd.addr] <= 8'hFF;
		end
		else if (pend && !memCmd.busy)
		begin
			pend <= 1'b0;
			cells[pAddr] <= pData;
		end
	end
endmodule

// ### nvm_write_control_tb_top.sv
// nvm_write_control_tb_top: self-checking bench for the nvm write control
module nvm_write_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import nwc_pkg::*;

	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	// short write time keeps the run brief
	localparam int WC = 16;
	logic clk;
	logic rst_n;
	logic warmReset;
	logic busWrite;
	logic busRead;
	logic [NWC_ADDR_W-1:0] busAddr;
	logic [7:0] busWdata;
	logic [7:0] busRdata;
	logic [7:0] memRdata;
	logic [7:0] v;
	nwc_mem_cmd_t memCmd;
	int nMismatch = 0;
	int samplesChecked = 0;
	int cycles = 0;

	nwc_write_control #(.WRITE_CYCLES(WC)) dut (.clk(clk), .rst_n(rst_n),
		.warmReset(warmReset), .busAddr(busAddr), .busWdata(busWdata),
		.busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
		.memRdata(memRdata), .memCmd(memCmd));
	nwc_nvm_model mem (.clk(clk), .memCmd(memCmd), .memRdata(memRdata));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic endOfTest;
		$display("checked %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			nMismatch++;
			endOfTest();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samplesChecked++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		busAddr <= a;
		busWdata <= d;
		busWrite <= 1'b1;
		@(posedge clk);
		busWrite <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		busAddr <= a;
		busRead <= 1'b1;
		@(posedge clk);
		busRead <= 1'b0;
		#1 d = busRdata;
	endtask

	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] got;
		rd(a, got);
		chk(got, e);
	endtask

	task automatic unlock;
		wr(ADR_UNLOCK_KEY, KEY_FIRST);
		wr(ADR_UNLOCK_KEY, KEY_SECOND);
	endtask

	task automatic waitIdle;
		int n;
		n = 0;
		while (memCmd.busy !== 1'b0 && n < 8)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk({7'h0, memCmd.busy}, 8'h00);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic resetValues;
		rc(ADR_CONTROL, 8'h00);
		rc(ADR_IRQ_FLAGS_TWO, 8'h00);
		wr(ADR_UNLOCK_KEY, KEY_FIRST);
		rc(ADR_UNLOCK_KEY, 8'h00);
		rc(3'h5, 8'h00);
		wr(ADR_CONTROL, 8'h20);
		rc(ADR_CONTROL, 8'h00);
	endtask

	// c already holds enable; selects decide the target
	task automatic runWrite(input logic [7:0] c, input nwc_target_t t);
		wr(ADR_CONTROL, c);
		unlock();
		wr(ADR_CONTROL, c | 8'h02);
		#1 chk({7'h0, memCmd.busy}, 8'h01);
		chk({6'h0, memCmd.target}, {6'h0, t});
		chk({7'h0, memCmd.erase}, {7'h0, t == TGT_EEPROM || c[4]});
		wr(ADR_CONTROL, 8'h00);
		wr(ADR_BYTE_DATA, 8'h99);
		rc(ADR_CONTROL, c | 8'h0A);
		repeat (WC - 9) @(posedge clk);
		#1 chk({7'h0, memCmd.busy}, 8'h01);
		waitIdle();
		rc(ADR_CONTROL, c & 8'hEF);
		rc(ADR_IRQ_FLAGS_TWO, 8'h10);
		wr(ADR_IRQ_FLAGS_TWO, 8'h00);
		rc(ADR_IRQ_FLAGS_TWO, 8'h00);
	endtask

	task automatic eepromWrite;
		wr(ADR_BYTE_ADDRESS, 8'h3C);
		wr(ADR_BYTE_DATA, 8'hA5);
		wr(ADR_CONTROL, 8'h04);
		rc(ADR_CONTROL, 8'h0C);
		runWrite(8'h04, TGT_EEPROM);
		wr(ADR_BYTE_DATA, 8'h00);
		wr(ADR_CONTROL, 8'h05);
		rc(ADR_BYTE_DATA, 8'hA5);
		rc(ADR_CONTROL, 8'h04);
	endtask

	task automatic flashWrites;
		runWrite(8'h84, TGT_FLASH);
		runWrite(8'h94, TGT_FLASH);
		runWrite(8'h54, TGT_CONFIG);
		runWrite(8'hC4, TGT_CONFIG);
	endtask

	task automatic improper;
		wr(ADR_CONTROL, 8'h00);
		unlock();
		wr(ADR_CONTROL, 8'h06);
		rc(ADR_CONTROL, 8'h0C);
		wr(ADR_CONTROL, 8'h04);
		wr(ADR_UNLOCK_KEY, KEY_FIRST);
		rd(ADR_BYTE_DATA, v);
		wr(ADR_UNLOCK_KEY, KEY_SECOND);
		wr(ADR_CONTROL, 8'h06);
		rc(ADR_CONTROL, 8'h0C);
		wr(ADR_CONTROL, 8'h04);
		wr(ADR_CONTROL, 8'h06);
		rc(ADR_CONTROL, 8'h0C);
		wr(ADR_CONTROL, 8'h81);
		rc(ADR_CONTROL, 8'h80);
		wr(ADR_CONTROL, 8'h41);
		rc(ADR_CONTROL, 8'h40);
	endtask

	// warm reset mid-write must leave selects and the error flag for tracing
	task automatic warmAbort;
		wr(ADR_CONTROL, 8'h94);
		unlock();
		wr(ADR_CONTROL, 8'h96);
		@(posedge clk);
		warmReset <= 1'b1;
		@(posedge clk);
		warmReset <= 1'b0;
		rc(ADR_CONTROL, 8'h88);
		rc(ADR_IRQ_FLAGS_TWO, 8'h00);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		busAddr = '0;
		busWdata = 8'h00;
		busWrite = 1'b0;
		busRead = 1'b0;
		warmReset = 1'b0;
		rst_n = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		resetValues();
		eepromWrite();
		flashWrites();
		improper();
		warmAbort();
		endOfTest();
	end
endmodule
